// ### src/ipfm_pkg.sv
// Summary of operation
// RULE1 - Inputs are debounced; filter setting 1..4 gives 0.888 to 3.555 ms.
// RULE2 - Filter selection resets to four, the longest filter time.
// RULE3 - Axis field: 0 disables, 1..6 one axis, F every axis.
// RULE4 - Codes 1D,1E,1F,07,1A,18: stroke ends, dog, alarm reset, torque, speed.
// RULE5 - Unassigned codes, 1C included, have no effect on any axis.
// RULE6 - Master must not write codes 1B or 20..29.
// RULE7 - Codes 11 and 12 give start direction and operation mode, plus others.
// RULE8 - Pins 1..12 have own selection parameters 1021..1032, same encoding.
// RULE9 - Defaults give axes 1..3 four pins: FLS, RLS, dog, none.
// RULE10 - Master accesses parameters through fieldbus, gated by write block.
// RULE11 - Axis field is bits 15:12, function code bits 7:0.
`default_nettype none
package ipfm_pkg;
  localparam int unsigned NPIN        = 12;
  localparam int unsigned NAXIS       = 6;
  localparam int unsigned NFUNC       = 10;
  localparam logic [15:0] PNU_FILTER  = 16'h03fc; // Parameter number 1020
  localparam logic [15:0] PNU_PIN1    = 16'h03fd; // Parameter number 1021
  localparam logic [15:0] FILTER_RST  = 16'h0004;
  localparam logic [15:0] PIN_RST [NPIN] = '{
    16'h101d, 16'h101e, 16'h101f, 16'h101c,
    16'h201d, 16'h201e, 16'h201f, 16'h201c,
    16'h301d, 16'h301e, 16'h301f, 16'h301c};
  localparam int unsigned AXIS_HI     = 15;
  localparam int unsigned AXIS_LO     = 12;
  localparam int unsigned CODE_HI     = 7;
  localparam logic [3:0]  AXIS_ALL    = 4'hf;
  localparam logic [3:0]  AXIS_MAX    = 4'h6;
  // Function codes and their bit in the per-axis function vector
  localparam logic [7:0] FC_ALARM_RST = 8'h07;
  localparam logic [7:0] FC_OP_ALM_RST = 8'h0e;
  localparam logic [7:0] FC_OP_START  = 8'h10;
  localparam logic [7:0] FC_START_DIR = 8'h11;
  localparam logic [7:0] FC_OP_MODE   = 8'h12;
  localparam logic [7:0] FC_SPEED_CHG = 8'h18;
  localparam logic [7:0] FC_TRQ_LIM   = 8'h1a;
  localparam logic [7:0] FC_FWD_END   = 8'h1d;
  localparam logic [7:0] FC_REV_END   = 8'h1e;
  localparam logic [7:0] FC_PROX_DOG  = 8'h1f;
  localparam logic [7:0] FUNC_CODE [NFUNC] = '{
    FC_FWD_END, FC_REV_END, FC_PROX_DOG, FC_ALARM_RST, FC_TRQ_LIM,
    FC_SPEED_CHG, FC_START_DIR, FC_OP_MODE, FC_OP_START, FC_OP_ALM_RST};
  // Filter times in microseconds and cycle counts at 200 MHz
  localparam real CLK_MHZ = 200.0;
  localparam real FILT_US [4] = '{888.0, 1777.0, 2666.0, 3555.0};
  localparam int unsigned FILT_CYC1 = int'(FILT_US[0] * CLK_MHZ);
  localparam int unsigned FILT_CYC2 = int'(FILT_US[1] * CLK_MHZ);
  localparam int unsigned FILT_CYC3 = int'(FILT_US[2] * CLK_MHZ);
  localparam int unsigned FILT_CYC4 = int'(FILT_US[3] * CLK_MHZ);
  localparam int unsigned CNT_W = 20;
endpackage : ipfm_pkg
`default_nettype wire

// ### src/ipfm_debounce.sv
`default_nettype none
// One pin's chatter filter: output follows input after it holds steady
module ipfm_debounce
  import ipfm_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             pin_in,
  input  wire logic [CNT_W-1:0] limit,
  output var  logic             pin_out
);
  logic             out_r;
  logic             out_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Restart count whenever input matches output; flip only after limit steady cycles
  always_comb
  begin
    out_nxt = out_r;
    cnt_nxt = '0;
    if (pin_in != out_r)
    begin
      if (cnt_r >= limit - CNT_W'(1))
        out_nxt = pin_in; // see RULE1
      else
        cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      out_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign pin_out = out_r;
endmodule : ipfm_debounce
`default_nettype wire

// ### src/ipfm_mapper.sv
`default_nettype none
// Input connector front end: filter, then route pins to axis functions
module ipfm_mapper
  import ipfm_pkg::*;
#(
  parameter int unsigned P_FILT_CYC1 = FILT_CYC1,
  parameter int unsigned P_FILT_CYC2 = FILT_CYC2,
  parameter int unsigned P_FILT_CYC3 = FILT_CYC3,
  parameter int unsigned P_FILT_CYC4 = FILT_CYC4
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic [ipfm_pkg::NPIN-1:0] input_connector,
  input  wire logic                     param_wr,
  input  wire logic [15:0]              param_num,
  input  wire logic [15:0]              param_wdata,
  input  wire logic                     parameter_write_block,
  output var  logic [15:0]              param_rdata,
  output var  logic                     param_valid,
  output var  logic                     param_wr_ok,
  output var  logic [ipfm_pkg::NPIN-1:0] pin_filtered,
  output var  logic [ipfm_pkg::NAXIS*ipfm_pkg::NFUNC-1:0] axis_func
);
  import ipfm_pkg::*;

  logic [15:0]      input_filter_select_r;
  logic [15:0]      filt_nxt;
  logic [15:0]      sel_r   [NPIN];
  logic [15:0]      sel_nxt [NPIN];
  logic [CNT_W-1:0] limit;
  logic [NPIN-1:0]  filt_pin;
  logic [15:0]      rdata_nxt;
  logic             valid_nxt;
  logic             wr_ok_nxt;
  logic [15:0]      rdata_r;
  logic             valid_r;
  logic             wr_ok_r;
  logic [NAXIS*NFUNC-1:0] func_nxt;
  logic [NAXIS*NFUNC-1:0] func_r;

  // Parameter writes land only on known numbers while the block allows
  always_comb
  begin
    filt_nxt  = input_filter_select_r;
    sel_nxt   = sel_r;
    rdata_nxt = 16'h0000;
    valid_nxt = 1'b0;
    wr_ok_nxt = 1'b0;
    if (param_num == PNU_FILTER)
    begin
      rdata_nxt = input_filter_select_r;
      valid_nxt = 1'b1;
      if (param_wr && !parameter_write_block) // see RULE10
      begin
        filt_nxt  = param_wdata;
        wr_ok_nxt = 1'b1;
      end
    end
    for (int i = 0; i < NPIN; i++)
    begin
      if (param_num == PNU_PIN1 + 16'(i)) // see RULE8
      begin
        rdata_nxt = sel_r[i];
        valid_nxt = 1'b1;
        if (param_wr && !parameter_write_block) // see RULE10
        begin
          sel_nxt[i] = param_wdata;
          wr_ok_nxt  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      input_filter_select_r <= FILTER_RST; // see RULE2
      sel_r   <= PIN_RST; // see RULE9
      rdata_r <= 16'h0000;
      valid_r <= 1'b0;
      wr_ok_r <= 1'b0;
    end
    else
    begin
      input_filter_select_r <= filt_nxt;
      sel_r   <= sel_nxt;
      rdata_r <= rdata_nxt;
      valid_r <= valid_nxt;
      wr_ok_r <= wr_ok_nxt;
    end
  end

  // Out-of-range filter settings fall back to the longest time for safety
  always_comb
  begin
    unique case (input_filter_select_r)
      16'h0001: limit = CNT_W'(P_FILT_CYC1); // see RULE1
      16'h0002: limit = CNT_W'(P_FILT_CYC2); // see RULE1
      16'h0003: limit = CNT_W'(P_FILT_CYC3); // see RULE1
      default:  limit = CNT_W'(P_FILT_CYC4); // see RULE1
    endcase
  end

  // One filter per connector pin
  generate
    for (genvar g = 0; g < NPIN; g++)
    begin : g_pin
      ipfm_debounce u_deb (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin_in  (input_connector[g]),
        .limit   (limit),
        .pin_out (filt_pin[g])
      );
    end
  endgenerate

  // OR every pin routed to an axis function; unlisted codes drop out
  always_comb
  begin
    logic [3:0] ax;
    logic [7:0] fc;
    ax = 4'h0;
    fc = 8'h00;
    func_nxt = '0;
    for (int p = 0; p < NPIN; p++)
    begin
      ax = sel_r[p][AXIS_HI:AXIS_LO]; // see RULE11
      fc = sel_r[p][CODE_HI:0]; // see RULE11
      for (int a = 0; a < NAXIS; a++)
      begin
        for (int f = 0; f < NFUNC; f++)
        begin
          // Codes 1B and 20..29 and 1C match no entry here
          if (fc == FUNC_CODE[f] && filt_pin[p] && // see RULE4 see RULE5 see RULE7
              (ax == AXIS_ALL || // see RULE3
               (ax != 4'h0 && ax <= AXIS_MAX && ax == 4'(a + 1))))
            func_nxt[a*NFUNC+f] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      func_r <= '0;
    else
      func_r <= func_nxt;
  end

  assign param_rdata  = rdata_r;
  assign param_valid  = valid_r;
  assign param_wr_ok  = wr_ok_r;
  assign pin_filtered = filt_pin;
  assign axis_func    = func_r;
endmodule : ipfm_mapper
`default_nettype wire

// ### dv/ipfm_sw.sv
`default_nettype none
// Switch bank on the input connector, with optional contact chatter
module ipfm_sw
(
  input  wire logic        clk_sys,
  input  wire logic [11:0] lvl,
  input  wire logic        chat,
  output wire logic [11:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bnc = 1'b0;
  // Bounce flips every cycle so no filter can ever see a steady level
  always @(negedge clk_sys)
    bnc <= ~bnc;
  assign pins = chat ? {12{bnc}} : lvl;
endmodule : ipfm_sw
`default_nettype wire

// ### dv/ipfm_chk.sv
`default_nettype none
// Port-level watch on the parameter access and the pin filter
module ipfm_chk
  import ipfm_pkg::*;
#(
  parameter int unsigned P_FILT_CYC1 = FILT_CYC1
)
(
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  input wire logic [NPIN-1:0]        input_connector,
  input wire logic                   param_wr,
  input wire logic [15:0]            param_num,
  input wire logic [15:0]            param_wdata,
  input wire logic                   parameter_write_block,
  input wire logic [15:0]            param_rdata,
  input wire logic                   param_valid,
  input wire logic                   param_wr_ok,
  input wire logic [NPIN-1:0]        pin_filtered,
  input wire logic [NAXIS*NFUNC-1:0] axis_func
);
  // Known parameter numbers; anything else reads as zero
  wire logic kn = param_num >= 16'd1020 && param_num <= 16'd1032;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Parameter access checks first; filtered pins 1 and 12 may only move to a level held for the shortest filter
  chk_wr_blocked:
    assert property (param_wr && parameter_write_block |=> !param_wr_ok)
      else $error("blocked write acknowledged");
  chk_wr_cause:
    assert property (param_wr_ok |-> $past(param_wr && kn))
      else $error("write ack without write");
  chk_valid_num:
    assert property ($past(resetn) |-> param_valid == $past(kn))
      else $error("valid flag wrong");
  chk_rdata_zero:
    assert property (!param_valid |-> param_rdata == 16'h0000)
      else $error("unknown number reads nonzero");
  chk_wr_readback:
    assert property (param_wr && !parameter_write_block && kn ##1
      !param_wr && $stable(param_num) |=> param_rdata == $past(param_wdata, 2))
      else $error("written value not read back");
  chk_axis_idle:
    assert property (pin_filtered == '0 |=> axis_func == '0)
      else $error("function active with no pin");
  chk_filt_first:
    assert property ($changed(pin_filtered[0]) |-> pin_filtered[0] ==
      $past(input_connector[0]) && pin_filtered[0] ==
      $past(input_connector[0], P_FILT_CYC1))
      else $error("pin 1 passed an unsettled level");
  chk_filt_last:
    assert property ($changed(pin_filtered[11]) |-> pin_filtered[11] ==
      $past(input_connector[11]) && pin_filtered[11] ==
      $past(input_connector[11], P_FILT_CYC1))
      else $error("pin 12 passed an unsettled level");
endmodule : ipfm_chk
bind ipfm_mapper ipfm_chk #(.P_FILT_CYC1(P_FILT_CYC1))
  ipfm_chk_inst (.*);
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ipfm_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, param_wr = 1'b0;
  logic        blk = 1'b0, chat = 1'b0, param_valid, param_wr_ok;
  logic [15:0] param_num = 16'h0000, param_wdata = 16'h0000, param_rdata;
  logic [11:0] lvl = 12'h000, pins, pin_filtered;
  logic [59:0] axis_func;
  int          err_count = 0, cmp_count = 0;
  // Routing cases: every axis, axis six, disabled, axis 7, unused codes
  logic [15:0] mv [7] = '{16'hf01d, 16'h601d, 16'h001d, 16'h701d,
                          16'h101c, 16'h1019, 16'h1000};
  logic [63:0] me [7] = '{64'h0004_0100_4010_0401, 64'h0004_0000_0000_0000,
                          0, 0, 0, 0, 0};
  // Free-running clock, 5 ns period
  always #2.5 clk_sys = ~clk_sys;
  ipfm_sw ipfm_sw_inst (.clk_sys, .lvl, .chat, .pins);
  ipfm_mapper #(.P_FILT_CYC1(4), .P_FILT_CYC2(8), .P_FILT_CYC3(12),
    .P_FILT_CYC4(16)) ipfm_mapper_inst (.clk_sys, .resetn,
    .input_connector(pins), .param_wr, .param_num, .param_wdata,
    .parameter_write_block(blk), .param_rdata, .param_valid,
    .param_wr_ok, .pin_filtered, .axis_func);
  task automatic chk(input string nm, input logic [63:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // Strobe is one cycle wide; number stays put for the readback.
  // Callers never pass codes 1B or 20..29
  task automatic wr(input logic [15:0] n, d);
    @(negedge clk_sys);
    param_wr = 1'b1;
    param_num = n;
    param_wdata = d;
    @(negedge clk_sys);
    param_wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [15:0] n, e);
    @(negedge clk_sys);
    param_num = n;
    @(negedge clk_sys);
    chk("param", param_rdata, e);
    chk("valid", param_valid, n >= 16'd1020 && n <= 16'd1032);
  endtask : rdc
  task results;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Run takes about 350 cycles; 4000 means a hang
  initial
  begin
    #20000;
    err_count++;
    results();
  end
  // Main sequence
  initial
  begin
    cyc(16);
    resetn = 1'b1;
    rdc(16'd1020, FILTER_RST);
    for (int i = 0; i < 12; i++)
      rdc(PNU_PIN1 + 16'(i), PIN_RST[i]);
    rdc(16'd1019, 16'h0000);
    $display("defaults done");
    blk = 1'b1;
    wr(PNU_PIN1, 16'h2007);
    chk("blocked_ok", param_wr_ok, 1'b0);
    blk = 1'b0;
    rdc(PNU_PIN1, 16'h101d);
    $display("write block done");
    for (int s = 1; s <= 4; s++)
    begin
      wr(16'd1020, 16'(s));
      chk("wr_ok", param_wr_ok, 1'b1);
      lvl = 12'h801;
      cyc(6);
      chk("fast", pin_filtered[0], s == 1);
      cyc(14);
      chk("held", axis_func, 64'h1);
      lvl = 12'h000;
      cyc(20);
    end
    $display("filter done");
    chat = 1'b1;
    cyc(30);
    chk("chatter", pin_filtered, 12'h000);
    chat = 1'b0;
    lvl = 12'h001;
    $display("chatter done");
    cyc(20);
    for (int f = 0; f < 10; f++)
    begin
      wr(PNU_PIN1, {8'h20, FUNC_CODE[f]});
      cyc(3);
      chk("func", axis_func, 64'h1 << (10 + f));
    end
    foreach (mv[k])
    begin
      wr(PNU_PIN1, mv[k]);
      cyc(3);
      chk("route", axis_func, me[k]);
    end
    $display("routing done");
    results();
  end
endmodule : testbench
`default_nettype wire
